// ==== rtl/ltm_top.v ====
// Mode, wake-up and protection control of a single-wire bus transceiver
// What this block does
// - Normal mode and enable falling sends the device to Sleep.
// - Sleep and enable rising goes straight to Normal, skipping Stand-By.
// - Stand-By and enable rising enters Normal.
// - Sleep: bus driver off, termination off, holding current source on.
// - Sleep: receiver off, receive and transmit pins undriven.
// - Sleep: regulator control floats; wake inputs and enable stay active.
// - Bus wake needs a falling edge then dominant beyond the bus filter time.
// - After bus wake stay asleep until bus returns recessive, then Stand-By.
// - Stand-By after bus wake puts a weak pull-down on transmit pin.
// - Local wake: falling edge then low beyond filter time, enter Stand-By.
// - Stand-By after local wake puts a strong pull-down on transmit pin.
// - Stand-By holds receive pin low after any wake, high after power-up.
// - Floating enable reads low, keeping Sleep or Stand-By.
// - Supply below reset threshold forces Stand-By, driver off, rest active.
// - After supply reset, receive pin high until enable brings Normal.
// - Undervoltage disables driver and receiver without changing mode.
// - Transmit dominant beyond time-out stops driving the bus.
// - After time-out, transmission resumes only on a transmit rising edge.
// - Over-temperature disables driver, no mode change, no pin report.
// - Driver re-enabled when temperature drops below release level.
// - After power-up start in Stand-By.
// - Entering Normal clears wake-source indications.
// - Normal: receive pin follows bus, bus follows transmit input.
// - Transmit low means dominant bus, high means recessive.
`timescale 1ns/100ps
`include "ltm_defs.vh"
module ltm_top #(
    parameter CW             = `LTM_CNT_W,
    parameter BUS_WAKE_CYC   = `LTM_BUS_WAKE_CYC,
    parameter LOCAL_WAKE_CYC = `LTM_LOCAL_WAKE_CYC,
    parameter TX_TIMEOUT_CYC = `LTM_TX_TIMEOUT_CYC,
    parameter RX_DEPTH       = 2,
    parameter RX_AW          = 1
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst_b,
    // Controller-side pins
    input  wire          mode_en_in,
    input  wire          txd_in,
    output reg           txd_weak_pd_oe,
    output reg           txd_strong_pd_oe,
    output wire          txd_out,
    output wire          rxd_out,
    output reg           rxd_oe,
    // Bus pin, open drain
    input  wire          bus_in,
    output wire          bus_out,
    output reg           bus_oe,
    output reg           bus_term_en,
    output reg           bus_hold_src_en,
    // Local wake and regulator control
    input  wire          local_wake_in,
    output reg           regulator_control_out,
    output reg           regulator_control_oe,
    // Supply and temperature comparators
    input  wire          supply_por_low,
    input  wire          supply_uv,
    input  wire          temp_above_shutdown,
    input  wire          temp_below_release,
    // Status
    output reg  [1:0]    mode_state,
    output reg           receiver_en,
    // Received bus level stream
    output wire          rx_level,
    output wire          rx_valid,
    input  wire          rx_ready
);
    localparam [1:0] ST_SLEEP   = `LTM_MODE_SLEEP;
    localparam [1:0] ST_STANDBY = `LTM_MODE_STANDBY;
    localparam [1:0] ST_NORMAL  = `LTM_MODE_NORMAL;
    localparam       NSYNC      = 5;

    // Open-drain pins only ever pull low
    assign txd_out = 1'b0;
    assign rxd_out = 1'b0;
    assign bus_out = 1'b0;

    // Level inputs from outside the clock domain
    wire [NSYNC-1:0] raw_in;
    reg  [NSYNC-1:0] sync1;
    reg  [NSYNC-1:0] sync2;
    assign raw_in = {temp_below_release, temp_above_shutdown, supply_uv,
                     supply_por_low, mode_en_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            // Two flops per level; reset low so a floating enable reads low
            always @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire en_s      = sync2[0];
    wire por_s     = sync2[1];
    wire uv_s      = sync2[2];
    wire hot_s     = sync2[3];
    wire cool_s    = sync2[4];

    // Bus, local wake and transmit qualifiers
    wire bus_lvl;
    wire bus_rose;
    wire bus_wake_q;
    wire wk_q;
    wire tx_lvl;
    wire tx_rose;
    wire tx_to_q;

    ltm_qual #(.CW(CW), .LIMIT(BUS_WAKE_CYC), .ARM_RESET(0)) u_bus_q (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (bus_in),
        .level    (bus_lvl),
        .fell     (),
        .rose     (bus_rose),
        .qual     (bus_wake_q)
    );

    ltm_qual #(.CW(CW), .LIMIT(LOCAL_WAKE_CYC), .ARM_RESET(0)) u_wk_q (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (local_wake_in),
        .level    (),
        .fell     (),
        .rose     (),
        .qual     (wk_q)
    );

    // Armed from reset so a transmit stuck low from power-up still times out
    ltm_qual #(.CW(CW), .LIMIT(TX_TIMEOUT_CYC), .ARM_RESET(1)) u_tx_q (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (txd_in),
        .level    (tx_lvl),
        .fell     (),
        .rose     (tx_rose),
        .qual     (tx_to_q)
    );

    // Mode machine and wake-source flags
    reg        en_last;
    reg        bus_wake_pend;
    reg        wake_bus_flag;
    reg        wake_local_flag;
    reg        por_flag;
    reg        tx_lock;
    reg        hot_lock;
    reg  [1:0] next_mode;
    wire       en_rise = en_s & ~en_last;
    wire       en_fall = ~en_s & en_last;

    always @* begin
        next_mode = mode_state;
        if (por_s) begin
            next_mode = ST_STANDBY;
        end else begin
            case (mode_state)
                ST_NORMAL: begin
                    if (en_fall) begin
                        next_mode = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (en_rise) begin
                        next_mode = ST_NORMAL;
                    end else if (wk_q) begin
                        next_mode = ST_STANDBY;
                    end else if (bus_wake_pend && bus_rose) begin
                        next_mode = ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (en_rise) begin
                        next_mode = ST_NORMAL;
                    end
                end
                default: begin
                    next_mode = ST_STANDBY;
                end
            endcase
        end
    end

    // Mode register starts in Stand-By
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_state <= `LTM_RST_MODE;
            en_last    <= 1'b0;
        end else begin
            mode_state <= next_mode;
            en_last    <= en_s;
        end
    end

    // Wake sources are remembered until Normal is entered or supply resets
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_wake_pend   <= 1'b0;
            wake_bus_flag   <= 1'b0;
            wake_local_flag <= 1'b0;
            por_flag        <= `LTM_RST_POR_FLAG;
        end else begin
            if (mode_state == ST_SLEEP && next_mode == ST_SLEEP && bus_wake_q) begin
                bus_wake_pend <= 1'b1;
            end else if (next_mode != ST_SLEEP) begin
                bus_wake_pend <= 1'b0;
            end
            if (por_s) begin
                por_flag        <= 1'b1;
                wake_bus_flag   <= 1'b0;
                wake_local_flag <= 1'b0;
            end else if (next_mode == ST_NORMAL && mode_state != ST_NORMAL) begin
                por_flag        <= 1'b0;
                wake_bus_flag   <= 1'b0;
                wake_local_flag <= 1'b0;
            end else if (mode_state == ST_SLEEP && next_mode == ST_STANDBY) begin
                por_flag        <= 1'b0;
                wake_local_flag <= wk_q;
                wake_bus_flag   <= ~wk_q;
            end
        end
    end

    // Protection locks; a new fault wins over a release in the same cycle
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_lock  <= 1'b0;
            hot_lock <= 1'b0;
        end else begin
            if (tx_to_q) begin
                tx_lock <= 1'b1;
            end else if (tx_rose) begin
                tx_lock <= 1'b0;
            end
            if (hot_s) begin
                hot_lock <= 1'b1;
            end else if (cool_s) begin
                hot_lock <= 1'b0;
            end
        end
    end

    // Receive stream: each new bus level is pushed while receiver_en is set; a full buffer holds it back
    reg  pushed_lvl;
    wire rx_in_ready;
    wire rx_src_valid = receiver_en & (bus_lvl != pushed_lvl);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pushed_lvl <= 1'b1;
        end else if (rx_src_valid & rx_in_ready) begin
            pushed_lvl <= bus_lvl;
        end
    end

    ltm_skid #(.W(1), .DEPTH(RX_DEPTH), .AW(RX_AW)) u_rx_buf (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_data   (bus_lvl),
        .in_valid  (rx_src_valid),
        .in_ready  (rx_in_ready),
        .out_data  (rx_level),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // Pin controls decoded from the current mode and protection state
    reg next_bus_oe;
    reg next_term;
    reg next_hold;
    reg next_rx_en;
    reg next_rxd_oe;
    reg next_weak;
    reg next_strong;
    reg next_reg_oe;

    always @* begin
        next_bus_oe = 1'b0;
        next_term   = 1'b1;
        next_hold   = 1'b0;
        next_rx_en  = 1'b0;
        next_rxd_oe = 1'b0;
        next_weak   = 1'b0;
        next_strong = 1'b0;
        next_reg_oe = 1'b1;
        case (mode_state)
            ST_NORMAL: begin
                next_rx_en  = ~uv_s;
                next_rxd_oe = ~uv_s & ~bus_lvl;
                // Transmit low drives dominant unless a guard is set
                next_bus_oe = ~tx_lvl & ~uv_s & ~tx_lock & ~hot_s & ~hot_lock;
            end
            ST_STANDBY: begin
                next_rxd_oe = (wake_bus_flag | wake_local_flag) & ~por_flag;
                next_strong = wake_local_flag;
                next_weak   = ~wake_local_flag;
            end
            ST_SLEEP: begin
                next_term   = 1'b0;
                next_hold   = 1'b1;
                next_reg_oe = 1'b0;
            end
            default: begin
                next_term = 1'b1;
            end
        endcase
    end

    // Pin outputs registered; this adds one cycle of bus-to-pin delay
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_oe                <= 1'b0;
            bus_term_en           <= 1'b1;
            bus_hold_src_en       <= 1'b0;
            receiver_en           <= 1'b0;
            rxd_oe                <= 1'b0;
            txd_weak_pd_oe        <= 1'b0;
            txd_strong_pd_oe      <= 1'b0;
            regulator_control_out <= 1'b0;
            regulator_control_oe  <= 1'b0;
        end else begin
            bus_oe                <= next_bus_oe;
            bus_term_en           <= next_term;
            bus_hold_src_en       <= next_hold;
            receiver_en           <= next_rx_en;
            rxd_oe                <= next_rxd_oe;
            txd_weak_pd_oe        <= next_weak;
            txd_strong_pd_oe      <= next_strong;
            regulator_control_out <= next_reg_oe;
            regulator_control_oe  <= next_reg_oe;
        end
    end
endmodule // ltm_top

// ==== rtl/ltm_defs.vh ====
// Constants for the mode, wake and protection control of the single-wire transceiver
`ifndef LTM_DEFS_VH
`define LTM_DEFS_VH

// Core clock rate in kHz (10 MHz)
`define LTM_CLK_KHZ          10000

// Filter and time-out figures in microseconds
`define LTM_BUS_WAKE_US      100
`define LTM_LOCAL_WAKE_US    100
`define LTM_TX_TIMEOUT_US    10000

// Cycle counts, least times rounded up
`define LTM_BUS_WAKE_CYC     ((`LTM_BUS_WAKE_US * `LTM_CLK_KHZ + 999) / 1000)
`define LTM_LOCAL_WAKE_CYC   ((`LTM_LOCAL_WAKE_US * `LTM_CLK_KHZ + 999) / 1000)
`define LTM_TX_TIMEOUT_CYC   ((`LTM_TX_TIMEOUT_US * `LTM_CLK_KHZ + 999) / 1000)

// Counter width for every duration measurement
`define LTM_CNT_W            20

// Mode codes shown on the mode output
`define LTM_MODE_SLEEP       2'h0
`define LTM_MODE_STANDBY     2'h1
`define LTM_MODE_NORMAL      2'h2

// Reset values
`define LTM_RST_MODE         2'h1
`define LTM_RST_POR_FLAG     1'h1

`endif

// ==== rtl/ltm_qual.v ====
// Pin synchroniser with edge detection and low-duration qualifier
`timescale 1ns/100ps
module ltm_qual #(
    parameter CW        = 20,
    parameter LIMIT     = 300,
    parameter ARM_RESET = 0
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst_b,
    // Raw pin and results
    input  wire          pin_in,
    output wire          level,
    output wire          fell,
    output wire          rose,
    output reg           qual
);
    localparam [CW-1:0] LIM = LIMIT[CW-1:0];

    reg          sync1;
    reg          sync2;
    reg          last;
    reg          armed;
    reg [CW-1:0] cnt;

    assign level = sync2;
    assign fell  = last & ~sync2;
    assign rose  = ~last & sync2;

    // Two flops before any logic looks at the pin
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            last  <= 1'b1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            last  <= sync2;
        end
    end

    // Low time counted from a falling edge; one pulse when it exceeds the limit
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= (ARM_RESET != 0);
            cnt   <= {CW{1'b0}};
            qual  <= 1'b0;
        end else begin
            qual <= 1'b0;
            if (fell) begin
                armed <= 1'b1;
                cnt   <= {CW{1'b0}};
            end else if (sync2) begin
                cnt <= {CW{1'b0}};
            end else if (armed) begin
                if (cnt == LIM) begin
                    qual  <= 1'b1;
                    armed <= 1'b0; // Single pulse per low period
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule // ltm_qual

// ==== rtl/ltm_skid.v ====
// Small FIFO with valid and ready on both sides
`timescale 1ns/100ps
module ltm_skid #(
    parameter W     = 1,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst_b,
    // Fill side
    input  wire [W-1:0]  in_data,
    input  wire          in_valid,
    output wire          in_ready,
    // Drain side
    output wire [W-1:0]  out_data,
    output wire          out_valid,
    input  wire          out_ready
);
    localparam [AW:0] FULL = DEPTH[AW:0];

    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire         push;
    wire         pop;

    assign in_ready  = (count != FULL);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage is written without reset; count guards stale entries
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, so DEPTH need not be a power of two
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // ltm_skid

// ==== verif/ltm_props.sv ====
// Concurrent checks on the transceiver mode, wake and protection outputs
`timescale 1ns/100ps
module ltm_props #(
    parameter TX_TIMEOUT_CYC = 20
) (
    // Clock and reset
    input wire       core_clk,
    input wire       rst_b,
    // Controller-side pins
    input wire       mode_en_in,
    input wire       txd_in,
    input wire       txd_weak_pd_oe,
    input wire       txd_strong_pd_oe,
    input wire       rxd_oe,
    // Bus pin
    input wire       bus_oe,
    input wire       bus_term_en,
    input wire       bus_hold_src_en,
    // Regulator
    input wire       regulator_control_out,
    input wire       regulator_control_oe,
    // Comparators
    input wire       supply_por_low,
    input wire       supply_uv,
    input wire       temp_above_shutdown,
    // Status and stream
    input wire [1:0] mode_state,
    input wire       receiver_en,
    input wire       rx_level,
    input wire       rx_valid,
    input wire       rx_ready
);
    reg [1:0]  live;
    reg [19:0] low_cnt;

    // Pins lag the mode by an edge; skip the first edges after reset
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            live    <= 2'h0;
            low_cnt <= 20'h00000;
        end else begin
            live    <= (live == 2'h3) ? live : live + 2'h1;
            low_cnt <= txd_in ? 20'h00000 : low_cnt + 20'h00001;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_sleep_pins: assert property (
        live == 2'h3 && $past(mode_state) == 2'h0 && mode_state == 2'h0
        |-> !bus_oe && !bus_term_en && bus_hold_src_en && !regulator_control_oe
        && !receiver_en && !rxd_oe && !txd_weak_pd_oe && !txd_strong_pd_oe)
        else $error("sleep pin state wrong");
    a_awake_pins: assert property (
        live == 2'h3 && $past(mode_state) != 2'h0 && mode_state != 2'h0
        |-> bus_term_en && regulator_control_out && regulator_control_oe && !bus_hold_src_en)
        else $error("awake pin state wrong");
    a_drive_only_normal: assert property (
        live == 2'h3 && $past(mode_state) != 2'h2 && mode_state != 2'h2 |-> !bus_oe)
        else $error("bus driven outside normal mode");
    a_wake_source_one: assert property (
        live == 2'h3 && $past(mode_state) == 2'h1 && mode_state == 2'h1
        |-> txd_weak_pd_oe != txd_strong_pd_oe && (!txd_strong_pd_oe || rxd_oe))
        else $error("wake source indication wrong");
    a_normal_clears: assert property (
        live == 2'h3 && $past(mode_state) == 2'h2 && mode_state == 2'h2
        |-> !txd_weak_pd_oe && !txd_strong_pd_oe)
        else $error("wake indication kept in normal mode");
    a_enable_rise: assert property (
        (mode_state != 2'h2 && $rose(mode_en_in) && !supply_por_low)
        ##1 (mode_en_in && !supply_por_low) [*4] |-> mode_state == 2'h2)
        else $error("enable rise did not reach normal");
    a_enable_fall: assert property (
        (mode_state == 2'h2 && $fell(mode_en_in))
        ##1 (!mode_en_in && !supply_por_low) [*4] |-> mode_state == 2'h0)
        else $error("enable fall did not reach sleep");
    a_por_standby: assert property (
        supply_por_low [*6] |-> mode_state == 2'h1 && !bus_oe)
        else $error("low supply did not force standby");
    a_uv_stages_off: assert property (
        supply_uv [*6] |-> !bus_oe && !receiver_en)
        else $error("undervoltage left stages on");
    a_temp_drive_off: assert property (
        temp_above_shutdown [*6] |-> !bus_oe)
        else $error("over temperature left driver on");
    a_tx_timeout: assert property (
        low_cnt > TX_TIMEOUT_CYC + 8 |-> !bus_oe)
        else $error("transmit time-out not applied");
    a_rx_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_level))
        else $error("stalled receive word changed");

    // Main scenarios reached
    cover property ($past(mode_state) == 2'h0 && mode_state == 2'h1);
    cover property ($past(mode_state) == 2'h0 && mode_state == 2'h2);
    cover property (rx_valid && !rx_ready);
endmodule // ltm_props

bind ltm_top ltm_props #(.TX_TIMEOUT_CYC(TX_TIMEOUT_CYC)) u_props (.*);

// ==== verif/ltm_far.sv ====
// Far side model: wired bus with a remote node, and the receive consumer
`timescale 1ns/100ps
module ltm_far (
    // Clock
    input  wire        core_clk,
    // Device bus pin
    input  wire        bus_out,
    input  wire        bus_oe,
    output wire        bus_in,
    // Bench controls for the remote node and consumer
    input  wire        remote_dom,
    input  wire        stall,
    // Receive stream
    input  wire        rx_level,
    input  wire        rx_valid,
    output wire        rx_ready,
    output reg  [15:0] got_cnt = 16'h0000,
    output reg         got_last = 1'b1
);
    // Pull-up holds recessive unless either node pulls the line down
    assign bus_in   = ~((bus_oe & ~bus_out) | remote_dom);
    assign rx_ready = ~stall;

    // Count accepted words and keep the last one
    always @(posedge core_clk) begin
        if (rx_valid && rx_ready) begin
            got_cnt  <= got_cnt + 16'h0001;
            got_last <= rx_level;
        end
    end
endmodule // ltm_far

// ==== verif/tb.sv ====
// Self-checking bench for the transceiver mode and wake control
`timescale 1ns/100ps
module tb;
    localparam TO = 20;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mode_en_in = 1'b0;
    logic        txd_in = 1'b1;
    logic        local_wake_in = 1'b1;
    logic        supply_por_low = 1'b0;
    logic        supply_uv = 1'b0;
    logic        temp_above_shutdown = 1'b0;
    logic        temp_below_release = 1'b1;
    logic        remote_dom = 1'b0;
    logic        hold = 1'b1;
    logic        stall = 1'b1;
    logic        bus_in, rx_ready, rx_level, rx_valid, got_last;
    logic        txd_weak_pd_oe, txd_strong_pd_oe, txd_out, rxd_out, rxd_oe;
    logic        bus_out, bus_oe, bus_term_en, bus_hold_src_en, receiver_en;
    logic        regulator_control_out, regulator_control_oe;
    logic [1:0]  mode_state;
    logic [15:0] got_cnt, base;
    integer      fails = 0;
    integer      checks_done = 0;
    integer      seed = 95519;
    integer      i;
    wire  [7:0]  pins = {bus_oe, bus_term_en, bus_hold_src_en, regulator_control_oe,
                         regulator_control_out, rxd_oe, txd_weak_pd_oe, txd_strong_pd_oe};

    always #50 core_clk = ~core_clk;

    ltm_top #(.BUS_WAKE_CYC(4), .LOCAL_WAKE_CYC(4), .TX_TIMEOUT_CYC(TO)) dut (.*);
    ltm_far far (.*);

    // Random consumer stalls, forced on while hold is set
    always @(negedge core_clk) stall <= hold | (($random(seed) & 3) == 0);

    task automatic cyc(input integer k);
        repeat (k) @(negedge core_clk);
    endtask

    task automatic chk_mode(input string what, input logic [1:0] exp, input logic [1:0] got);
        chk_vec(what, {6'h00, exp}, {6'h00, got});
    endtask

    task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic set_en(input logic v);
        mode_en_in = v;
        cyc(6);
    endtask

    task automatic summarize;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Consecutive accepted words always alternate in level
    always @(posedge core_clk)
        if (rx_valid === 1'b1 && rx_ready === 1'b1 && got_cnt != 16'h0000)
            chk_vec("rx word", {7'h00, ~got_last}, {7'h00, rx_level});

    initial begin
        cyc(10);
        rst_b = 1'b1;
        hold = 1'b0;
        cyc(4);
        chk_mode("power-up mode", 2'h1, mode_state);
        chk_vec("power-up pins", 8'h5A, pins);
        set_en(1'b1);
        chk_mode("normal", 2'h2, mode_state);
        chk_vec("normal pins", 8'h58, pins);
        chk_vec("od data", 8'h00, {5'h00, txd_out, rxd_out, bus_out});
        txd_in = 1'b0;
        cyc(8);
        chk_vec("dominant pins", 8'hDC, pins);
        cyc(TO + 6);
        chk_vec("time-out pins", 8'h58, pins);
        txd_in = 1'b1;
        cyc(2);
        txd_in = 1'b0;
        cyc(8);
        chk_vec("released pins", 8'hDC, pins);
        txd_in = 1'b1;
        cyc(3);
        // Hot, then inside the hysteresis band: lock holds
        temp_above_shutdown = 1'b1;
        temp_below_release = 1'b0;
        txd_in = 1'b0;
        cyc(6);
        chk_vec("hot pins", 8'h58, pins);
        chk_mode("hot mode", 2'h2, mode_state);
        temp_above_shutdown = 1'b0;
        cyc(4);
        chk_vec("band pins", 8'h58, pins);
        temp_below_release = 1'b1;
        cyc(8);
        chk_vec("cool pins", 8'hDC, pins);
        txd_in = 1'b1;
        cyc(3);
        supply_uv = 1'b1;
        txd_in = 1'b0;
        cyc(6);
        chk_vec("uv pins", 8'h58, pins);
        chk_vec("uv receiver", 8'h00, {7'h00, receiver_en});
        chk_mode("uv mode", 2'h2, mode_state);
        supply_uv = 1'b0;
        cyc(8);
        chk_vec("uv gone pins", 8'hDC, pins);
        txd_in = 1'b1;
        cyc(3);
        set_en(1'b0);
        chk_mode("sleep", 2'h0, mode_state);
        chk_vec("sleep pins", 8'h20, pins);
        // Short dominant filtered; long one waits for recessive
        remote_dom = 1'b1;
        cyc(3);
        remote_dom = 1'b0;
        cyc(6);
        chk_mode("short bus", 2'h0, mode_state);
        remote_dom = 1'b1;
        cyc(12);
        chk_mode("bus held low", 2'h0, mode_state);
        remote_dom = 1'b0;
        cyc(6);
        chk_mode("bus wake", 2'h1, mode_state);
        chk_vec("bus wake pins", 8'h5E, pins);
        set_en(1'b1);
        chk_vec("cleared pins", 8'h58, pins);
        set_en(1'b0);
        local_wake_in = 1'b0;
        cyc(3);
        local_wake_in = 1'b1;
        cyc(6);
        chk_mode("short local", 2'h0, mode_state);
        local_wake_in = 1'b0;
        cyc(12);
        chk_mode("local wake", 2'h1, mode_state);
        chk_vec("local pins", 8'h5D, pins);
        local_wake_in = 1'b1;
        set_en(1'b1);
        set_en(1'b0);
        mode_en_in = 1'b1;
        for (i = 0; i < 6; i++) begin
            cyc(1);
            if (mode_state === 2'h1)
                chk_mode("no standby step", 2'h2, mode_state);
        end
        chk_mode("sleep to normal", 2'h2, mode_state);
        // Fill the buffer under a stall, then drain it
        hold = 1'b1;
        cyc(2);
        base = got_cnt;
        for (i = 0; i < 3; i++) begin
            remote_dom = ~remote_dom;
            cyc(8);
        end
        chk_vec("rx valid", 8'h01, {7'h00, rx_valid});
        hold = 1'b0;
        cyc(12);
        chk_vec("rx held", 8'h03, got_cnt[7:0] - base[7:0]);
        base = got_cnt;
        for (i = 0; i < 40; i++) begin
            remote_dom = ~remote_dom;
            cyc(8 + ($random(seed) & 7));
        end
        cyc(12);
        chk_vec("rx count", 8'h28, got_cnt[7:0] - base[7:0]);
        remote_dom = 1'b0;
        cyc(4);
        // Supply reset in normal ignores enable edges
        supply_por_low = 1'b1;
        mode_en_in = 1'b0;
        cyc(3);
        mode_en_in = 1'b1;
        cyc(6);
        chk_mode("por mode", 2'h1, mode_state);
        chk_vec("por pins", 8'h5A, pins);
        supply_por_low = 1'b0;
        cyc(6);
        chk_mode("por kept", 2'h1, mode_state);
        set_en(1'b0);
        set_en(1'b1);
        chk_mode("por left", 2'h2, mode_state);
        summarize();
    end

    // Watchdog against a hang
    initial begin
        repeat (8000) @(posedge core_clk);
        fails++;
        summarize();
    end
endmodule // tb
